// ==== design/telemetry_word_port.sv ====
// Purpose: Telemetry word output with computer-word preemption, plus acquisition fetch.
// Assumes: Strobe, fetch-done and returned data come from pins; words come from local logic.
// Notes: The displaced multiplexer word is parked and offered again after the computer word.
`timescale 1ns/1ps
module telemetry_word_port
  import telemetry_word_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Multiplexer word source
  input wire logic [DATA_W-1:0] mux_data,
  input wire logic [TAG_W-1:0] mux_tag,
  input wire logic [MODE_W-1:0] mux_mode,
  input wire logic mux_valid,
  output logic mux_ready,
  // Flight computer transfer
  input wire logic [DATA_W-1:0] cpu_data,
  input wire logic [TAG_W-1:0] cpu_tag,
  input wire logic [MODE_W-1:0] cpu_mode,
  input wire logic cpu_valid,
  output logic cpu_ready,
  // Telemetry pins
  input wire logic read_strobe,
  output logic [FRAME_W-1:0] tlm_word,
  output logic tlm_is_cpu,
  // Fetch command side
  input wire logic fetch_start,
  input wire logic [FETCH_ADDR_W-1:0] fetch_addr_in,
  input wire logic [WAIT_W-1:0] fetch_wait,
  output logic fetch_busy,
  output logic fetch_ok,
  output logic fetch_timeout,
  output logic [FETCH_DATA_W-1:0] fetch_result,
  // Acquisition unit pins
  output logic fetch_req,
  output logic [FETCH_ADDR_W-1:0] fetch_addr,
  input wire logic fetch_done,
  input wire logic [FETCH_DATA_W-1:0] fetch_data
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic strobe_s;
  logic done_s;
  logic strobe_d_reg;
  logic [FETCH_DATA_W-1:0] fdata_s;

  sync2 u_sync_strobe (.ref_clk(ref_clk), .rst_n(rst_n), .d(read_strobe), .q(strobe_s));
  sync2 u_sync_done (.ref_clk(ref_clk), .rst_n(rst_n), .d(fetch_done), .q(done_s));

  // The data bits are held stable by the unit while fetch-done is up, so per-bit sync is safe.
  genvar gi;
  generate
    for (gi = 0; gi < FETCH_DATA_W; gi++) begin : g_fdata
      sync2 u_sync_fd (.ref_clk(ref_clk), .rst_n(rst_n), .d(fetch_data[gi]), .q(fdata_s[gi]));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Telemetry word path
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] park_reg;
  logic [WORD_W-1:0] park_next;
  logic park_valid_reg;
  logic park_valid_next;
  logic [FRAME_W-1:0] tlm_word_next;
  logic tlm_is_cpu_next;
  logic word_valid_reg;
  logic word_valid_next;
  logic strobe_rise;
  logic [WORD_W-1:0] mux_word;
  logic [WORD_W-1:0] cpu_word;
  logic mux_ready_next;
  logic cpu_ready_next;
  logic strobe_d_next;

  function automatic logic [FRAME_W-1:0] frame(input logic [WORD_W-1:0] w);
    frame = {~(^w), w};
  endfunction

  always_comb begin
    mux_word = {mux_mode, mux_tag, mux_data};
    mux_word[TAG_LSB+TAG_SRC_BIT] = 1'b0;
    cpu_word = {cpu_mode, cpu_tag, cpu_data};
    cpu_word[TAG_LSB+TAG_SRC_BIT] = 1'b1;
    strobe_d_next = strobe_s;
    strobe_rise = strobe_s & ~strobe_d_reg;
    tlm_word_next = tlm_word;
    tlm_is_cpu_next = tlm_is_cpu;
    word_valid_next = word_valid_reg;
    park_next = park_reg;
    park_valid_next = park_valid_reg;
    mux_ready_next = 1'b0;
    cpu_ready_next = 1'b0;
    if (strobe_rise) begin
      word_valid_next = 1'b0;
    end
    if (cpu_valid && !cpu_ready && !(tlm_is_cpu && word_valid_reg && !strobe_rise)) begin
      // A pending, unread multiplexer word is parked so it is not lost.
      if (word_valid_reg && !strobe_rise && !tlm_is_cpu) begin
        park_next = tlm_word[WORD_W-1:0];
        park_valid_next = 1'b1;
      end
      tlm_word_next = frame(cpu_word);
      tlm_is_cpu_next = 1'b1;
      word_valid_next = 1'b1;
      cpu_ready_next = 1'b1;
    end else if (!word_valid_next) begin
      if (park_valid_reg) begin
        tlm_word_next = frame(park_reg);
        tlm_is_cpu_next = 1'b0;
        word_valid_next = 1'b1;
        park_valid_next = 1'b0;
      end else if (mux_valid && !mux_ready) begin
        tlm_word_next = frame(mux_word);
        tlm_is_cpu_next = 1'b0;
        word_valid_next = 1'b1;
        mux_ready_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strobe_d_reg <= 1'b0;
      tlm_word <= FRAME_RESET;
      tlm_is_cpu <= 1'b0;
      word_valid_reg <= 1'b0;
      park_reg <= '0;
      park_valid_reg <= 1'b0;
      mux_ready <= 1'b0;
      cpu_ready <= 1'b0;
    end else begin
      strobe_d_reg <= strobe_d_next;
      tlm_word <= tlm_word_next;
      tlm_is_cpu <= tlm_is_cpu_next;
      word_valid_reg <= word_valid_next;
      park_reg <= park_next;
      park_valid_reg <= park_valid_next;
      mux_ready <= mux_ready_next;
      cpu_ready <= cpu_ready_next;
    end
  end

  // ----------------------------------------------------------------
  // Acquisition fetch
  // ----------------------------------------------------------------
  fetch_state_e state_reg;
  fetch_state_e state_next;
  logic [WAIT_W-1:0] wait_reg;
  logic [WAIT_W-1:0] wait_next;
  logic fetch_req_next;
  logic [FETCH_ADDR_W-1:0] fetch_addr_next;
  logic fetch_busy_next;
  logic fetch_ok_next;
  logic fetch_timeout_next;
  logic [FETCH_DATA_W-1:0] fetch_result_next;

  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    fetch_req_next = 1'b0;
    fetch_addr_next = fetch_addr;
    fetch_busy_next = fetch_busy;
    fetch_ok_next = 1'b0;
    fetch_timeout_next = 1'b0;
    fetch_result_next = fetch_result;
    case (state_reg)
      FETCH_IDLE: begin
        if (fetch_start) begin
          fetch_addr_next = fetch_addr_in;
          fetch_req_next = 1'b1;
          fetch_busy_next = 1'b1;
          wait_next = (fetch_wait == '0) ? FETCH_WAIT_DEFAULT : fetch_wait;
          state_next = FETCH_REQ;
        end
      end
      FETCH_REQ: begin
        // Done may still be high from the last fetch; wait for it to drop first.
        // The wait budget runs here too, so a unit stuck at done cannot hang the port.
        if (wait_reg == '0) begin
          fetch_timeout_next = 1'b1;
          fetch_busy_next = 1'b0;
          state_next = FETCH_IDLE;
        end else begin
          wait_next = wait_reg - 1'b1;
          if (!done_s) begin
            state_next = FETCH_WAIT;
          end
        end
      end
      FETCH_WAIT: begin
        if (done_s) begin
          fetch_result_next = fdata_s;
          fetch_ok_next = 1'b1;
          fetch_busy_next = 1'b0;
          state_next = FETCH_IDLE;
        end else if (wait_reg == '0) begin
          fetch_timeout_next = 1'b1;
          fetch_busy_next = 1'b0;
          state_next = FETCH_IDLE;
        end else begin
          wait_next = wait_reg - 1'b1;
        end
      end
      default: begin
        state_next = FETCH_IDLE;
        fetch_busy_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= FETCH_IDLE;
      wait_reg <= '0;
      fetch_req <= 1'b0;
      fetch_addr <= ADDR_RESET;
      fetch_busy <= 1'b0;
      fetch_ok <= 1'b0;
      fetch_timeout <= 1'b0;
      fetch_result <= FDATA_RESET;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      fetch_req <= fetch_req_next;
      fetch_addr <= fetch_addr_next;
      fetch_busy <= fetch_busy_next;
      fetch_ok <= fetch_ok_next;
      fetch_timeout <= fetch_timeout_next;
      fetch_result <= fetch_result_next;
    end
  end

endmodule // telemetry_word_port

// ==== inc/telemetry_word_pkg.sv ====
// Purpose: Shared constants for the telemetry word port.
// Assumes: Single 200 MHz clock, synchronous active-low reset.
// Notes: Word layout is data, tag, mode, then odd parity on top.
package telemetry_word_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int DATA_W = 26;
  localparam int TAG_W = 8;
  localparam int MODE_W = 6;
  localparam int WORD_W = DATA_W + TAG_W + MODE_W;
  localparam int DATA_LSB = 0;
  localparam int TAG_LSB = DATA_LSB + DATA_W;
  localparam int MODE_LSB = TAG_LSB + TAG_W;
  localparam int TAG_SRC_BIT = 2;
  localparam int FRAME_W = WORD_W + 1;

  // ----------------------------------------------------------------
  // Acquisition fetch
  // ----------------------------------------------------------------
  localparam int FETCH_ADDR_W = 12;
  localparam int FETCH_DATA_W = 10;
  localparam int WAIT_W = 16;
  localparam logic [WAIT_W-1:0] FETCH_WAIT_DEFAULT = 16'h0400;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [FRAME_W-1:0] FRAME_RESET = {1'b1, {WORD_W{1'b0}}};
  localparam logic [FETCH_ADDR_W-1:0] ADDR_RESET = 12'h000;
  localparam logic [FETCH_DATA_W-1:0] FDATA_RESET = 10'h000;

  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b00,
    FETCH_REQ = 2'b01,
    FETCH_WAIT = 2'b10
  } fetch_state_e;

endpackage

// ==== design/sync2.sv ====
// Purpose: Two-flop synchroniser for a single pin level.
// Assumes: Input is asynchronous to ref_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module sync2 (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Level
  input wire logic d,
  output logic q
);

  logic meta_reg;
  logic meta_next;
  logic q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end

endmodule // sync2

// ==== tb/telemetry_word_port_assertions.sv ====
// Purpose: Port-level checks for the telemetry word port.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Attached by bind from the bench top file.
`timescale 1ns/1ps
module telemetry_word_port_assertions
  import telemetry_word_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Telemetry side
  input wire logic [FRAME_W-1:0] tlm_word,
  input wire logic tlm_is_cpu,
  input wire logic mux_ready,
  input wire logic cpu_ready,
  input wire logic [DATA_W-1:0] cpu_data,
  // Fetch side
  input wire logic fetch_start,
  input wire logic fetch_busy,
  input wire logic [FETCH_ADDR_W-1:0] fetch_addr_in,
  input wire logic fetch_req,
  input wire logic [FETCH_ADDR_W-1:0] fetch_addr,
  input wire logic fetch_done,
  input wire logic fetch_ok,
  input wire logic fetch_timeout
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_start; fetch_start && !fetch_busy; endsequence
  sequence s_issue; fetch_req && fetch_busy; endsequence
  a_odd_parity: assert property (^tlm_word) else $error("telemetry word parity even");
  a_tag_source: assert property (tlm_word[TAG_LSB+TAG_SRC_BIT] == tlm_is_cpu) else $error("tag bit wrong");
  a_cpu_word: assert property (cpu_ready |-> tlm_is_cpu && tlm_word[DATA_W-1:0] == $past(cpu_data))
    else $error("computer word not shown");
  a_mux_pulse: assert property (mux_ready |-> !tlm_is_cpu ##1 !mux_ready) else $error("mux ready bad");
  a_start_issue: assert property (s_start |=> s_issue ##0 fetch_addr == $past(fetch_addr_in))
    else $error("fetch request or address wrong");
  a_req_pulse: assert property (fetch_req |=> !fetch_req) else $error("fetch request too long");
  a_addr_hold: assert property (!fetch_req |-> $stable(fetch_addr)) else $error("fetch address moved");
  a_ok_done: assert property ($rose(fetch_ok) |-> $past(fetch_done, 2)) else $error("ok before done");
  a_end_idle: assert property (fetch_ok || fetch_timeout |-> !fetch_busy ##1 !(fetch_ok || fetch_timeout))
    else $error("fetch end wrong");
endmodule // telemetry_word_port_assertions

// ==== tb/acq_unit_model.sv ====
// Purpose: Behavioural acquisition unit answering fetch requests.
// Assumes: Request and address arrive together for one cycle.
// Notes: Mute models a unit whose address never matches.
`timescale 1ns/1ps
module acq_unit_model
  import telemetry_word_pkg::*;
#(
  parameter int LAT = 5
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Request side
  input wire logic fetch_req,
  input wire logic [FETCH_ADDR_W-1:0] fetch_addr,
  input wire logic mute,
  // Answer side
  output logic fetch_done = 1'b0,
  output logic [FETCH_DATA_W-1:0] fetch_data = 10'h000
);
  logic [FETCH_ADDR_W-1:0] addr_q;
  int cnt;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt <= 0;
      fetch_done <= 1'b0;
    end else if (fetch_req) begin
      cnt <= LAT;
      addr_q <= fetch_addr;
      fetch_done <= 1'b0;
      fetch_data <= ~fetch_data;
    end else if (cnt != 0 && !mute) begin
      cnt <= cnt - 1;
      if (cnt == 3) fetch_data <= addr_q[FETCH_DATA_W-1:0] ^ 10'h2a5;
      if (cnt == 1) fetch_done <= 1'b1;
    end
  end
endmodule // acq_unit_model

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the telemetry word port.
// Assumes: The bench plays the telemetry equipment and the word sources.
// Notes: Fetch waits are kept small, except in the two fetches that use the 16'h0400 default wait.
`timescale 1ns/1ps
module tb_top
  import telemetry_word_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [WORD_W-1:0] mux_w = '0;
  logic [WORD_W-1:0] cpu_w = '0;
  logic mux_valid = 1'b0;
  logic cpu_valid = 1'b0;
  logic read_strobe = 1'b0;
  logic fetch_start = 1'b0;
  logic mute = 1'b0;
  logic [FETCH_ADDR_W-1:0] fetch_addr_in = '0;
  logic [WAIT_W-1:0] fetch_wait = '0;
  logic mux_ready, cpu_ready, tlm_is_cpu, fetch_busy, fetch_ok, fetch_timeout, fetch_req, fetch_done;
  logic [FRAME_W-1:0] tlm_word;
  logic [FETCH_DATA_W-1:0] fetch_result, fetch_data;
  logic [FETCH_ADDR_W-1:0] fetch_addr;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  telemetry_word_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .mux_data(mux_w[DATA_W-1:0]),
    .mux_tag(mux_w[TAG_LSB+:TAG_W]), .mux_mode(mux_w[MODE_LSB+:MODE_W]), .mux_valid(mux_valid),
    .mux_ready(mux_ready), .cpu_data(cpu_w[DATA_W-1:0]), .cpu_tag(cpu_w[TAG_LSB+:TAG_W]),
    .cpu_mode(cpu_w[MODE_LSB+:MODE_W]), .cpu_valid(cpu_valid), .cpu_ready(cpu_ready),
    .read_strobe(read_strobe), .tlm_word(tlm_word), .tlm_is_cpu(tlm_is_cpu), .fetch_start(fetch_start),
    .fetch_addr_in(fetch_addr_in), .fetch_wait(fetch_wait), .fetch_busy(fetch_busy), .fetch_ok(fetch_ok),
    .fetch_timeout(fetch_timeout), .fetch_result(fetch_result), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_done(fetch_done), .fetch_data(fetch_data));
  acq_unit_model #(.LAT(5)) unit (.ref_clk(ref_clk), .rst_n(rst_n), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .mute(mute), .fetch_done(fetch_done), .fetch_data(fetch_data));
  always #2.5 ref_clk = ~ref_clk;
  // A hung handshake must still reach the verdict.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  function automatic logic [FRAME_W-1:0] frm(input logic [WORD_W-1:0] w, input logic c);
    w[TAG_LSB+TAG_SRC_BIT] = c;
    return {~^w, w};
  endfunction
  task automatic chk(input string n, input logic [FRAME_W-1:0] e, input logic [FRAME_W-1:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic send(input logic [WORD_W-1:0] w, input logic c);
    int k;
    k = 0;
    @(posedge ref_clk);
    if (c) cpu_w <= w;
    else mux_w <= w;
    cpu_valid <= c;
    mux_valid <= !c;
    @(posedge ref_clk);
    while ((c ? cpu_ready : mux_ready) !== 1'b1 && k < 100) begin
      k++;
      @(posedge ref_clk);
    end
    cpu_valid <= 1'b0;
    mux_valid <= 1'b0;
    chk("tlm_word", frm(w, c), tlm_word);
    chk("tlm_is_cpu", c, tlm_is_cpu);
  endtask
  task automatic strobe();
    read_strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    read_strobe <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic t_stream();
    send(40'h5a_d3f0_0ff1, 1'b0);
    strobe();
    send(40'hff_ffff_ffff, 1'b0);
  endtask
  task automatic t_preempt();
    send(40'h3c_e00f_a5a5, 1'b1);
    strobe();
    chk("reloaded_word", frm(40'hff_ffff_ffff, 1'b0), tlm_word);
    chk("reloaded_is_cpu", 1'b0, tlm_is_cpu);
    strobe();
    send(40'h00_0000_0000, 1'b0);
  endtask
  task automatic t_fetch(input logic [FETCH_ADDR_W-1:0] a, input logic m, input logic [WAIT_W-1:0] w);
    int k;
    int exp_k;
    k = 0;
    exp_k = ((w == '0) ? int'(FETCH_WAIT_DEFAULT) : int'(w)) + 1;
    @(posedge ref_clk);
    mute <= m;
    fetch_addr_in <= a;
    fetch_wait <= w;
    fetch_start <= 1'b1;
    @(posedge ref_clk);
    fetch_start <= 1'b0;
    @(posedge ref_clk);
    while (fetch_ok !== 1'b1 && fetch_timeout !== 1'b1 && k < 2000) begin
      k++;
      @(posedge ref_clk);
    end
    chk("fetch_addr", a, fetch_addr);
    chk("fetch_timeout", m, fetch_timeout);
    chk("fetch_ok", !m, fetch_ok);
    if (m) chk("timeout_delay", 1'b1, k == exp_k);
    else chk("fetch_result", a[FETCH_DATA_W-1:0] ^ 10'h2a5, fetch_result);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_stream();
    t_preempt();
    t_fetch(12'h000, 1'b0, 16'h0040);
    t_fetch(12'hfff, 1'b0, 16'h0000);
    t_fetch(12'h5a5, 1'b1, 16'h0008);
    t_fetch(12'h0a5, 1'b1, 16'h0000);
    results();
  end
endmodule // tb_top
bind telemetry_word_port telemetry_word_port_assertions chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .tlm_word(tlm_word), .tlm_is_cpu(tlm_is_cpu),
  .mux_ready(mux_ready), .cpu_ready(cpu_ready), .cpu_data(cpu_data), .fetch_start(fetch_start),
  .fetch_busy(fetch_busy), .fetch_addr_in(fetch_addr_in), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .fetch_done(fetch_done), .fetch_ok(fetch_ok), .fetch_timeout(fetch_timeout));
